// >>> inc/drt_pkg.sv
// Purpose: constants and types for the dual reload down-count timer
// Assumes: 16-bit register port, word-indexed addresses
// Notes: offsets are register indexes on the plain port
package drt_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam logic [15:0] OFS_PRESCALE = 16'hc030;
	localparam logic [15:0] OFS_RUN = 16'hc031;
	localparam logic [15:0] OFS_IRQ_STATUS = 16'hc032;
	localparam logic [15:0] OFS_IRQ_CLEAR = 16'hc033;
	localparam logic [15:0] OFS_T0_RELOAD_LO = 16'hc034;
	localparam logic [15:0] OFS_T0_RELOAD_HI = 16'hc035;
	localparam logic [15:0] OFS_T0_COUNT_LO = 16'hc036;
	localparam logic [15:0] OFS_T0_COUNT_HI = 16'hc037;
	localparam logic [15:0] OFS_T1_RELOAD_LO = 16'hc038;
	localparam logic [15:0] OFS_T1_RELOAD_HI = 16'hc039;
	localparam logic [15:0] OFS_T1_COUNT_LO = 16'hc03a;
	localparam logic [15:0] OFS_T1_COUNT_HI = 16'hc03b;
	localparam logic [15:0] OFS_IRQ_ENABLE = 16'hc03c;
	localparam int PRESCALE_W = 8;
	localparam int RUN_BIT_ZERO = 0;
	localparam int RUN_BIT_ONE = 1;
	localparam logic [7:0] PRESCALE_RESET = 8'h00;
	localparam logic [1:0] RUN_RESET = 2'h0;
	localparam logic [31:0] TIMER_RESET = 32'h0000_0000;
	localparam logic [15:0] READ_UNMAPPED = 16'h0000;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} drt_bus_req_t;

	typedef enum logic [1:0] {
		DRT_IDLE = 2'b01,
		DRT_RUN = 2'b10
	} drt_state_t;
endpackage : drt_pkg

// >>> rtl/drt_timer.sv
// Purpose: two 32-bit down counters with shared prescaler and a reload value of their own each
// Assumes: single 20 MHz clock, 16-bit register port, read data one cycle later
// Notes: counter words written by software take effect at once
`timescale 1ns/1ps
`default_nettype none
// How it works
// - prescaler divides ref_clk by field plus one into one tick for both timers
// - run register bit 1 runs timer one, bit 0 runs timer zero
// - each timer keeps a 32-bit start value loaded on start or reload
// - interrupt period is start value plus one ticks
// - timer zero start value split low/high at two consecutive addresses
// - timer zero live counter halves readable and writable at consecutive addresses
// - timer one uses the next four addresses, same arrangement
// - reading counter halves returns the current count
// - counter write replaces count once, then reloads from start value
// - each timer raises its own request on underflow
// - on enable, load start value then decrement every tick
// - passing below zero signals, reloads and keeps counting while enabled
module drt_timer
	import drt_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire drt_bus_req_t bus_req,
	output logic [DATA_W-1:0] rd_data,
	output logic timer0_irq,
	output logic timer1_irq,
	output logic irq
);

	// configuration state
	logic [7:0] tick_prescale_field;
	logic [1:0] run_enable;
	logic run_bit_zero;
	logic run_bit_one;
	logic [1:0] irq_enable;
	logic [1:0] irq_status;

	// prescaler state
	logic [7:0] prescale_cnt;
	logic tick;

	// timer zero state
	logic [31:0] timer0_reload;
	logic [31:0] timer0_count;
	drt_state_t timer0_state;
	logic timer0_underflow;

	// timer one state
	logic [31:0] timer1_reload;
	logic [31:0] timer1_count;
	drt_state_t timer1_state;
	logic timer1_underflow;

	// decoded write strobes
	logic write_hi;
	logic wr_prescale;
	logic wr_run;
	logic wr_irq_enable;
	logic wr_irq_clear;
	logic wr_t0_reload;
	logic wr_t0_count;
	logic wr_t1_reload;
	logic wr_t1_count;

	// halves are written on their own, so a 32-bit update takes two writes
	function automatic logic [31:0] put_half(input logic [31:0] word, input logic hi, input logic [15:0] val);
		put_half = hi ? {val, word[15:0]} : {word[31:16], val};
	endfunction : put_half

	function automatic logic [15:0] get_half(input logic [31:0] word, input logic hi);
		get_half = hi ? word[31:16] : word[15:0];
	endfunction : get_half

	// true when the address names either half of the pair starting at base
	function automatic logic pair_hit(input logic [15:0] addr, input logic [15:0] base);
		pair_hit = (addr[15:1] == base[15:1]);
	endfunction : pair_hit

	// next counter value; a software write beats a tick in the same cycle
	function automatic logic [31:0] next_count_of(
		input drt_state_t st,
		input logic run,
		input logic wr,
		input logic hi,
		input logic [15:0] wdata,
		input logic tk,
		input logic [31:0] cnt,
		input logic [31:0] rl
	);
		logic [31:0] result;
		result = cnt;
		case (st)
			DRT_IDLE: begin
				if (wr) begin
					result = put_half(cnt, hi, wdata);
				end else if (run) begin
					result = rl;
				end
			end
			DRT_RUN: begin
				if (wr) begin
					result = put_half(cnt, hi, wdata);
				end else if (run && tk) begin
					if (cnt == 32'h0000_0000) begin
						result = rl;
					end else begin
						result = cnt - 32'h0000_0001;
					end
				end
			end
			default: begin
				result = cnt;
			end
		endcase
		next_count_of = result;
	endfunction : next_count_of

	// underflow is the tick that finds the count at zero while running
	function automatic logic wraps(
		input drt_state_t st,
		input logic run,
		input logic wr,
		input logic tk,
		input logic [31:0] cnt
	);
		wraps = (st == DRT_RUN) && run && !wr && tk && (cnt == 32'h0000_0000);
	endfunction : wraps

	// address decode
	assign write_hi = bus_req.addr[0];
	assign wr_prescale = bus_req.wr && (bus_req.addr == OFS_PRESCALE);
	assign wr_run = bus_req.wr && (bus_req.addr == OFS_RUN);
	assign wr_irq_enable = bus_req.wr && (bus_req.addr == OFS_IRQ_ENABLE);
	assign wr_irq_clear = bus_req.wr && (bus_req.addr == OFS_IRQ_CLEAR);
	assign wr_t0_reload = bus_req.wr && pair_hit(bus_req.addr, OFS_T0_RELOAD_LO);
	assign wr_t0_count = bus_req.wr && pair_hit(bus_req.addr, OFS_T0_COUNT_LO);
	assign wr_t1_reload = bus_req.wr && pair_hit(bus_req.addr, OFS_T1_RELOAD_LO);
	assign wr_t1_count = bus_req.wr && pair_hit(bus_req.addr, OFS_T1_COUNT_LO);
	assign run_bit_zero = run_enable[RUN_BIT_ZERO];
	assign run_bit_one = run_enable[RUN_BIT_ONE];

	// prescaler; a field change applies at once, a count at or past the new field wraps on the next cycle
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			prescale_cnt <= 8'h00;
			tick <= 1'b0;
		end else if (prescale_cnt >= tick_prescale_field) begin
			prescale_cnt <= 8'h00;
			tick <= 1'b1;
		end else begin
			prescale_cnt <= prescale_cnt + 8'h01;
			tick <= 1'b0;
		end
	end

	// prescale field
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_prescale_field <= PRESCALE_RESET;
		end else if (wr_prescale) begin
			tick_prescale_field <= bus_req.wdata[7:0];
		end
	end

	// run bits
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			run_enable <= RUN_RESET;
		end else if (wr_run) begin
			run_enable <= bus_req.wdata[1:0];
		end
	end

	// interrupt enable
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_enable <= 2'h0;
		end else if (wr_irq_enable) begin
			irq_enable <= bus_req.wdata[1:0];
		end
	end

	// timer zero start value
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			timer0_reload <= TIMER_RESET;
		end else if (wr_t0_reload) begin
			timer0_reload <= put_half(timer0_reload, write_hi, bus_req.wdata);
		end
	end

	// timer one start value
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			timer1_reload <= TIMER_RESET;
		end else if (wr_t1_reload) begin
			timer1_reload <= put_half(timer1_reload, write_hi, bus_req.wdata);
		end
	end

	// timer zero run state; a counter write while idle delays the start by a cycle
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			timer0_state <= DRT_IDLE;
		end else begin
			case (timer0_state)
				DRT_IDLE: begin
					if (run_bit_zero && !wr_t0_count) begin
						timer0_state <= DRT_RUN;
					end
				end
				DRT_RUN: begin
					if (!run_bit_zero) begin
						timer0_state <= DRT_IDLE;
					end
				end
				default: begin
					timer0_state <= DRT_IDLE;
				end
			endcase
		end
	end

	// timer one run state
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			timer1_state <= DRT_IDLE;
		end else begin
			case (timer1_state)
				DRT_IDLE: begin
					if (run_bit_one && !wr_t1_count) begin
						timer1_state <= DRT_RUN;
					end
				end
				DRT_RUN: begin
					if (!run_bit_one) begin
						timer1_state <= DRT_IDLE;
					end
				end
				default: begin
					timer1_state <= DRT_IDLE;
				end
			endcase
		end
	end

	// timer zero counter; held while idle
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			timer0_count <= TIMER_RESET;
		end else begin
			timer0_count <= next_count_of(timer0_state, run_bit_zero, wr_t0_count, write_hi,
				bus_req.wdata, tick, timer0_count, timer0_reload);
		end
	end

	// timer one counter; held while idle
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			timer1_count <= TIMER_RESET;
		end else begin
			timer1_count <= next_count_of(timer1_state, run_bit_one, wr_t1_count, write_hi,
				bus_req.wdata, tick, timer1_count, timer1_reload);
		end
	end

	// timer zero underflow event
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			timer0_underflow <= 1'b0;
		end else begin
			timer0_underflow <= wraps(timer0_state, run_bit_zero, wr_t0_count, tick, timer0_count);
		end
	end

	// timer one underflow event
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			timer1_underflow <= 1'b0;
		end else begin
			timer1_underflow <= wraps(timer1_state, run_bit_one, wr_t1_count, tick, timer1_count);
		end
	end

	// request pulses straight from flops, one cycle after the underflow
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			timer0_irq <= 1'b0;
		end else begin
			timer0_irq <= timer0_underflow;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			timer1_irq <= 1'b0;
		end else begin
			timer1_irq <= timer1_underflow;
		end
	end

	// sticky status; a new event wins over a clear in the same cycle
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_status <= 2'h0;
		end else if (wr_irq_clear) begin
			irq_status <= (irq_status & ~bus_req.wdata[1:0]) | {timer1_underflow, timer0_underflow};
		end else begin
			irq_status <= irq_status | {timer1_underflow, timer0_underflow};
		end
	end

	// level request; lags the status by one cycle to stay a plain flop output
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_enable);
		end
	end

	// read port, data valid the cycle after the strobe and zero otherwise
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data <= READ_UNMAPPED;
		end else if (bus_req.rd) begin
			case (bus_req.addr)
				OFS_PRESCALE: begin
					rd_data <= {8'h00, tick_prescale_field};
				end
				OFS_RUN: begin
					rd_data <= {14'h0, run_enable};
				end
				OFS_IRQ_STATUS: begin
					rd_data <= {14'h0, irq_status};
				end
				OFS_IRQ_ENABLE: begin
					rd_data <= {14'h0, irq_enable};
				end
				OFS_T0_RELOAD_LO, OFS_T0_RELOAD_HI: begin
					rd_data <= get_half(timer0_reload, bus_req.addr[0]);
				end
				OFS_T0_COUNT_LO, OFS_T0_COUNT_HI: begin
					rd_data <= get_half(timer0_count, bus_req.addr[0]);
				end
				OFS_T1_RELOAD_LO, OFS_T1_RELOAD_HI: begin
					rd_data <= get_half(timer1_reload, bus_req.addr[0]);
				end
				OFS_T1_COUNT_LO, OFS_T1_COUNT_HI: begin
					rd_data <= get_half(timer1_count, bus_req.addr[0]);
				end
				default: begin
					rd_data <= READ_UNMAPPED;
				end
			endcase
		end else begin
			rd_data <= READ_UNMAPPED;
		end
	end

endmodule : drt_timer
`default_nettype wire

// >>> tb/drt_timer_props.sv
// Purpose: bound checker for the dual timer
// Assumes: bench keeps prescale non-zero while timers run
// Notes: shadows run, enable and prescale from bus writes
`timescale 1ns/1ps
`default_nettype none
module drt_timer_props
	import drt_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire drt_bus_req_t bus_req,
	input wire logic [DATA_W-1:0] rd_data,
	input wire logic timer0_irq,
	input wire logic timer1_irq,
	input wire logic irq
);
	logic [1:0] run_q;
	logic [1:0] ien_q;
	logic [7:0] pre_q;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			run_q <= 2'h0;
			ien_q <= 2'h0;
			pre_q <= 8'h00;
		end else if (bus_req.wr) begin
			if (bus_req.addr == OFS_RUN) run_q <= bus_req.wdata[1:0];
			if (bus_req.addr == OFS_IRQ_ENABLE) ien_q <= bus_req.wdata[1:0];
			if (bus_req.addr == OFS_PRESCALE) pre_q <= bus_req.wdata[7:0];
		end
	end
	property p_rd_idle; !bus_req.rd |=> rd_data == 16'h0000; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	// three cycles allow a pulse already launched when the run bit drops
	property p_stop0; (!run_q[0]) [*3] |-> !timer0_irq; endproperty
	a_stop0: assert property (p_stop0) else $error("stopped timer0 pulsed");
	property p_stop1; (!run_q[1]) [*3] |-> !timer1_irq; endproperty
	a_stop1: assert property (p_stop1) else $error("stopped timer1 pulsed");
	property p_irq_rise; (timer0_irq && ien_q[0]) || (timer1_irq && ien_q[1]) |=> irq; endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq did not follow");
	property p_irq_low; (ien_q == 2'h0) [*2] |-> !irq; endproperty
	a_irq_low: assert property (p_irq_low) else $error("irq while masked");
	property p_pulse0; timer0_irq && pre_q != 8'h00 |=> !timer0_irq; endproperty
	a_pulse0: assert property (p_pulse0) else $error("timer0 pulse too long");
	property p_run_rd; bus_req.rd && bus_req.addr == OFS_RUN |=> rd_data == {14'h0000, $past(run_q)}; endproperty
	a_run_rd: assert property (p_run_rd) else $error("run readback wrong");
	property p_pre_rd; bus_req.rd && bus_req.addr == OFS_PRESCALE |=> rd_data == {8'h00, $past(pre_q)}; endproperty
	a_pre_rd: assert property (p_pre_rd) else $error("prescale readback wrong");
	c_t0: cover property (timer0_irq);
	c_t1: cover property (timer1_irq);
	c_irq: cover property (irq);
endmodule : drt_timer_props
bind drt_timer drt_timer_props u_props (.ref_clk(ref_clk), .reset_n(reset_n), .bus_req(bus_req),
	.rd_data(rd_data), .timer0_irq(timer0_irq), .timer1_irq(timer1_irq), .irq(irq));
`default_nettype wire

// >>> tb/drt_timer_tb.sv
// Purpose: register-level bench for the dual timer
// Assumes: 20 MHz clock, reads answer one cycle later
// Notes: periods measured pulse to pulse
`timescale 1ns/1ps
`default_nettype none
module drt_timer_tb;
	import drt_pkg::*;
	logic ref_clk;
	logic reset_n;
	drt_bus_req_t bus_req;
	logic [DATA_W-1:0] rd_data;
	logic timer0_irq;
	logic timer1_irq;
	logic irq;
	int fails;
	int samples_checked;
	int n;
	drt_timer dut (.ref_clk(ref_clk), .reset_n(reset_n), .bus_req(bus_req), .rd_data(rd_data),
		.timer0_irq(timer0_irq), .timer1_irq(timer1_irq), .irq(irq));
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic acc(input logic [15:0] a, input logic [15:0] d, input logic w);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge ref_clk);
		bus_req.wr <= 1'b0;
		bus_req.rd <= 1'b0;
		#1;
	endtask : acc
	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		acc(a, 16'h0000, 1'b0);
		check("rd", rd_data, exp);
	endtask : rd
	// first call syncs to a pulse, second returns the pulse spacing
	task automatic gap(input logic t1, output int k);
		k = 0;
		do begin
			@(posedge ref_clk);
			#1;
			k++;
		end while ((t1 ? timer1_irq : timer0_irq) !== 1'b1 && k < 500);
		if (k >= 500) fails++;
	endtask : gap
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : summarize
	initial begin
		#200000;
		fails++;
		summarize();
	end
	initial begin
		fails = 0;
		samples_checked = 0;
		bus_req = '0;
		reset_n = 1'b0;
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 12; i++) if (i != 2 && i != 3) rd(16'(32'hc030 + i), 16'h0000);
		acc(OFS_T1_RELOAD_HI, 16'ha5c3, 1'b1);
		rd(OFS_T1_RELOAD_HI, 16'ha5c3);
		acc(OFS_T1_RELOAD_HI, 16'h0000, 1'b1);
		acc(OFS_T1_RELOAD_LO, 16'h0001, 1'b1);
		acc(OFS_T0_RELOAD_LO, 16'h0004, 1'b1);
		rd(OFS_T0_RELOAD_LO, 16'h0004);
		acc(OFS_PRESCALE, 16'h0003, 1'b1);
		rd(OFS_PRESCALE, 16'h0003);
		acc(OFS_IRQ_ENABLE, 16'h0003, 1'b1);
		acc(OFS_RUN, 16'h0001, 1'b1);
		rd(OFS_RUN, 16'h0001);
		gap(1'b0, n);
		gap(1'b0, n);
		check("t0 period", n, 20);
		gap(1'b0, n);
		@(posedge ref_clk);
		#1;
		check("irq", irq, 1'b1);
		acc(OFS_IRQ_CLEAR, 16'h0001, 1'b1);
		@(posedge ref_clk);
		#1;
		check("irq clr", irq, 1'b0);
		rd(OFS_T0_COUNT_HI, 16'h0000);
		acc(OFS_T0_COUNT_LO, 16'h0000, 1'b0);
		check("count lo", 32'(rd_data <= 16'h0004), 32'h1);
		acc(OFS_RUN, 16'h0002, 1'b1);
		gap(1'b1, n);
		gap(1'b1, n);
		check("t1 period", n, 8);
		acc(OFS_T0_COUNT_LO, 16'h0000, 1'b0);
		n = rd_data;
		rd(OFS_T0_COUNT_LO, 16'(n));
		acc(OFS_T0_COUNT_LO, 16'h1234, 1'b1);
		rd(OFS_T0_COUNT_LO, 16'h1234);
		summarize();
	end
endmodule : drt_timer_tb
`default_nettype wire
